/* File: design/wcc_map.vh */
// Constants for the write checksum check and alert block.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef WCC_MAP_VH
`define WCC_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define WCC_ADDR_MODE_FIVE 8'h00
`define WCC_ADDR_MODE_ONE 8'h04
`define WCC_ADDR_MODE_TWO 8'h08
`define WCC_ADDR_MPR_THREE 8'h0c
`define WCC_ADDR_STATUS 8'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define WCC_MODE5_CRC_ERR 3
`define WCC_MODE5_DM_EN 10
`define WCC_MODE5_WDBI_EN 11
`define WCC_MODE5_RDBI_EN 12
`define WCC_MODE1_STRB_EN 11
`define WCC_MR2_CRC_EN 12
`define WCC_MULTI3_CRC_FLAG 7

// ----------------------------------------------------------------
// Reset values and widths
// ----------------------------------------------------------------
`define WCC_MR_W 16
`define WCC_MR_RESET 16'h0000

// ----------------------------------------------------------------
// Shared pin function codes
// ----------------------------------------------------------------
`define WCC_PIN_NONE 2'h0
`define WCC_PIN_DBI 2'h1
`define WCC_PIN_DM 2'h2
`define WCC_PIN_STRB 2'h3

// ----------------------------------------------------------------
// Timing, in clocks of pclk, and pulse counter width in bits
// ----------------------------------------------------------------
`define WCC_CRC_PW_CYC 10
`define WCC_PAR_PW_CYC 46
`define WCC_CNT_W 8

// ----------------------------------------------------------------
// Checksum polynomial and read inversion threshold
// ----------------------------------------------------------------
`define WCC_CRC_POLY 8'h07
`define WCC_DBI_ZERO_LIMIT 4'h4

`endif

/* File: design/wcc_crc_tree.v */
// Eight-bit checksum tree over one chopped x8 write burst.
// Assumes a transfer-major burst: byte t of the burst sits in bits [t*8+7:t*8].
`include "wcc_map.vh"

module wcc_crc_tree (
  input wire [63:0] burst,
  input wire [7:0] pin_bits,
  input wire addr_bit_two,
  input wire use_pin,
  output reg [7:0] crc
);

  // ----------------------------------------------------------------
  // Tree input vector and checksum
  // ----------------------------------------------------------------
  integer q;
  integer t;
  integer i;
  integer src;
  reg [71:0] d;
  reg fb;

  always @* begin
    d = {72{1'b1}};
    crc = 8'h00;
    fb = 1'b0;
    src = 0;
    for (q = 0; q < 9; q = q + 1) begin
      for (t = 0; t < 4; t = t + 1) begin
        // The chop keeps four transfers; the upper half is forced to one.
        src = addr_bit_two ? t + 4 : t;
        if (q < 8) begin
          d[q * 8 + t] = burst[src * 8 + q];
        end else begin
          d[q * 8 + t] = use_pin ? pin_bits[src] : 1'b1;
        end
      end
    end
    // Serial form of the parallel tree; synthesis flattens it to XORs.
    for (i = 0; i < 72; i = i + 1) begin
      fb = crc[7] ^ d[i];
      crc = {crc[6:0], 1'b0} ^ (fb ? `WCC_CRC_POLY : 8'h00);
    end
  end

endmodule

/* File: design/wcc_dbi_lane.v */
// Bus inversion for one byte: read encoding and write decoding.
// Assumes the caller gates both enables by mode and organisation.
`include "wcc_map.vh"

module wcc_dbi_lane (
  input wire [7:0] rd_byte,
  input wire rd_en,
  input wire [7:0] wr_byte,
  input wire wr_en,
  input wire wr_inv_n,
  output wire [7:0] rd_out,
  output wire rd_inv_n,
  output wire [7:0] wr_out
);

  // ----------------------------------------------------------------
  // Zero count
  // ----------------------------------------------------------------
  function [3:0] zero_count;
    input [7:0] b;
    integer k;
    begin
      zero_count = 4'h0;
      for (k = 0; k < 8; k = k + 1) begin
        zero_count = zero_count + {3'h0, ~b[k]};
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Encode and decode
  // ----------------------------------------------------------------
  wire rd_flip;

  assign rd_flip = rd_en & (zero_count(rd_byte) > `WCC_DBI_ZERO_LIMIT);
  assign rd_out = rd_flip ? ~rd_byte : rd_byte;
  assign rd_inv_n = ~rd_flip;
  assign wr_out = (wr_en & ~wr_inv_n) ? ~wr_byte : wr_byte;

endmodule

/* File: design/wcc_write_crc_alert.v */
// Write checksum check, alert pulse, error status and shared pin function.
// Assumes an APB master on pclk, burst pins that need synchronising, a
// parity checker and a core read path on pclk, and an external pull-up.
//
// Contract
// - Each checksum bit is an XOR of fixed burst bits and constant ones.
// - In chopped x8 bursts address bit two selects low or high nibble.
// - Tree takes 36 bits; pin bits are ones unless mask or inversion on.
// - Compare computed and received checksum; alert starts the next clock.
// - Checksum errors use the same alert output as parity errors.
// - Checksum alert lasts about ten clocks; parity alert exceeds 45.
// - Pulse runs from drive low to release; controller pulls high.
// - Error sets mode five bit 3 and multipurpose three bit 7.
// - Status stays one until a mode-set write clears it to zero.
// - Inversion exists only in x8 and x16, not x4.
// - Inversion leaves no more than half the lines low per edge.
// - One pin carries inversion, mask or strobe, chosen by mode bits.
// - Read lane with more than four zeros is inverted, pin driven low.
// - Write lane with pin low is inverted before storing.
`include "wcc_map.vh"

module wcc_write_crc_alert #(
  parameter DEV_X4 = 0,
  parameter [`WCC_CNT_W-1:0] CRC_PW = `WCC_CRC_PW_CYC,
  parameter [`WCC_CNT_W-1:0] PAR_PW = `WCC_PAR_PW_CYC
) (
  input wire pclk,
  input wire presetn,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire wr_valid,
  input wire wr_chop,
  input wire wr_addr_bit_two,
  input wire [63:0] wr_dq,
  input wire [7:0] wr_pin,
  input wire [7:0] wr_crc,
  input wire par_err,
  output reg store_valid,
  output reg [63:0] store_data,
  output reg [7:0] store_keep,
  input wire rd_valid,
  input wire rd_mpr,
  input wire [63:0] rd_data,
  output reg rd_dq_valid,
  output reg [63:0] rd_dq,
  output reg [7:0] rd_pin,
  output reg [1:0] pin_func,
  output reg alert_out,
  output reg alert_oe
);

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  localparam SEL_NONE = 3'h0;
  localparam SEL_MODE5 = 3'h1;
  localparam SEL_MODE1 = 3'h2;
  localparam SEL_MR2 = 3'h3;
  localparam SEL_MULTI3 = 3'h4;
  localparam SEL_STAT = 3'h5;

  function [2:0] reg_sel;
    input [7:0] a;
    begin
      case (a)
        `WCC_ADDR_MODE_FIVE: reg_sel = SEL_MODE5;
        `WCC_ADDR_MODE_ONE: reg_sel = SEL_MODE1;
        `WCC_ADDR_MODE_TWO: reg_sel = SEL_MR2;
        `WCC_ADDR_MPR_THREE: reg_sel = SEL_MULTI3;
        `WCC_ADDR_STATUS: reg_sel = SEL_STAT;
        default: reg_sel = SEL_NONE;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg [`WCC_MR_W-1:0] mode_reg_five;
  reg [`WCC_MR_W-1:0] mode_reg_one;
  reg [`WCC_MR_W-1:0] mode_reg_two;
  reg [31:0] next_prdata;
  reg wr_valid_m;
  reg wr_valid_s;
  reg wr_chop_m;
  reg wr_chop_s;
  reg wr_nib_m;
  reg wr_nib_s;
  reg [63:0] wr_dq_m;
  reg [63:0] wr_dq_s;
  reg [7:0] wr_pin_m;
  reg [7:0] wr_pin_s;
  reg [7:0] wr_crc_m;
  reg [7:0] wr_crc_s;
  reg crc_bad;
  reg [7:0] last_crc;
  reg [`WCC_CNT_W-1:0] alert_cnt;
  reg [`WCC_CNT_W-1:0] next_alert_cnt;
  reg alert_is_crc;
  wire [2:0] sel;
  wire access;
  wire inv_ok;
  wire dm_en;
  wire wdbi_en;
  wire rdbi_en;
  wire strobe_en;
  wire crc_en;
  wire [7:0] calc_crc;
  wire [63:0] wr_decoded;
  wire [63:0] rd_encoded;
  wire [7:0] rd_inv_n;

  assign sel = reg_sel(paddr);
  assign access = psel & penable & pready;
  // The x4 organisation has no inversion or mask function at all.
  assign inv_ok = (DEV_X4 == 0);
  assign dm_en = inv_ok & mode_reg_five[`WCC_MODE5_DM_EN];
  assign wdbi_en = inv_ok & mode_reg_five[`WCC_MODE5_WDBI_EN];
  assign rdbi_en = inv_ok & mode_reg_five[`WCC_MODE5_RDBI_EN];
  assign strobe_en = inv_ok & mode_reg_one[`WCC_MODE1_STRB_EN];
  assign crc_en = mode_reg_two[`WCC_MR2_CRC_EN];

  // ----------------------------------------------------------------
  // APB slave: one wait state, error on unmapped addresses
  // ----------------------------------------------------------------
  always @* begin
    case (sel)
      SEL_MODE5: next_prdata = {16'h0000, mode_reg_five};
      SEL_MODE1: next_prdata = {16'h0000, mode_reg_one};
      SEL_MR2: next_prdata = {16'h0000, mode_reg_two};
      SEL_MULTI3: next_prdata = {24'h000000, mode_reg_five[`WCC_MODE5_CRC_ERR], 7'h00};
      SEL_STAT: next_prdata = {16'h0000, last_crc, 5'h00, alert_is_crc, alert_oe, crc_en};
      default: next_prdata = 32'h00000000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready) begin
        pslverr <= (sel == SEL_NONE);
        prdata <= pwrite ? 32'h00000000 : next_prdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode registers and sticky checksum error status
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg_five <= `WCC_MR_RESET;
      mode_reg_one <= `WCC_MR_RESET;
      mode_reg_two <= `WCC_MR_RESET;
    end else begin
      if (access && pwrite && sel == SEL_MODE5) begin
        mode_reg_five <= pwdata[`WCC_MR_W-1:0];
        // Only a zero written clears the flag; a new error in that cycle wins.
        mode_reg_five[`WCC_MODE5_CRC_ERR] <= crc_bad |
          (pwdata[`WCC_MODE5_CRC_ERR] & mode_reg_five[`WCC_MODE5_CRC_ERR]);
      end else if (crc_bad) begin
        mode_reg_five[`WCC_MODE5_CRC_ERR] <= 1'b1;
      end
      if (access && pwrite && sel == SEL_MODE1) begin
        mode_reg_one <= pwdata[`WCC_MR_W-1:0];
      end
      if (access && pwrite && sel == SEL_MR2) begin
        mode_reg_two <= pwdata[`WCC_MR_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Burst pins pass two flip-flops before any logic looks at them
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_valid_m <= 1'b0;
      wr_valid_s <= 1'b0;
      wr_chop_m <= 1'b0;
      wr_chop_s <= 1'b0;
      wr_nib_m <= 1'b0;
      wr_nib_s <= 1'b0;
      wr_dq_m <= 64'h0000000000000000;
      wr_dq_s <= 64'h0000000000000000;
      wr_pin_m <= 8'hff;
      wr_pin_s <= 8'hff;
      wr_crc_m <= 8'h00;
      wr_crc_s <= 8'h00;
    end else begin
      wr_valid_m <= wr_valid;
      wr_valid_s <= wr_valid_m;
      wr_chop_m <= wr_chop;
      wr_chop_s <= wr_chop_m;
      wr_nib_m <= wr_addr_bit_two;
      wr_nib_s <= wr_nib_m;
      wr_dq_m <= wr_dq;
      wr_dq_s <= wr_dq_m;
      wr_pin_m <= wr_pin;
      wr_pin_s <= wr_pin_m;
      wr_crc_m <= wr_crc;
      wr_crc_s <= wr_crc_m;
    end
  end

  // ----------------------------------------------------------------
  // Checksum tree and comparison
  // ----------------------------------------------------------------
  wcc_crc_tree u_tree (
    .burst(wr_dq_s),
    .pin_bits(wr_pin_s),
    .addr_bit_two(wr_nib_s),
    .use_pin(dm_en | wdbi_en),
    .crc(calc_crc)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_bad <= 1'b0;
      last_crc <= 8'h00;
    end else begin
      // Full bursts are not covered here, so only chopped ones are checked.
      crc_bad <= wr_valid_s & wr_chop_s & crc_en & (calc_crc != wr_crc_s);
      if (wr_valid_s) begin
        last_crc <= calc_crc;
      end
    end
  end

  // ----------------------------------------------------------------
  // Alert pulse shared by checksum and parity errors
  // ----------------------------------------------------------------
  always @* begin
    next_alert_cnt = (alert_cnt != {`WCC_CNT_W{1'b0}}) ?
      alert_cnt - {{(`WCC_CNT_W-1){1'b0}}, 1'b1} : {`WCC_CNT_W{1'b0}};
    // Overlapping events keep the longer remaining low time.
    if (crc_bad && next_alert_cnt < CRC_PW) begin
      next_alert_cnt = CRC_PW;
    end
    if (par_err && next_alert_cnt < PAR_PW) begin
      next_alert_cnt = PAR_PW;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alert_cnt <= {`WCC_CNT_W{1'b0}};
      alert_oe <= 1'b0;
      alert_out <= 1'b0;
      alert_is_crc <= 1'b0;
    end else begin
      alert_cnt <= next_alert_cnt;
      // Driving only pulls low; release leaves the line to the pull-up.
      alert_oe <= (next_alert_cnt != {`WCC_CNT_W{1'b0}});
      alert_out <= 1'b0;
      if (crc_bad) begin
        alert_is_crc <= 1'b1;
      end else if (par_err) begin
        alert_is_crc <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-transfer inversion lanes
  // ----------------------------------------------------------------
  genvar t;
  generate
    for (t = 0; t < 8; t = t + 1) begin : g_lane
      wcc_dbi_lane u_lane (
        .rd_byte(rd_data[t*8+7:t*8]),
        .rd_en(rdbi_en & ~rd_mpr),
        .wr_byte(wr_dq_s[t*8+7:t*8]),
        .wr_en(wdbi_en),
        .wr_inv_n(wr_pin_s[t]),
        .rd_out(rd_encoded[t*8+7:t*8]),
        .rd_inv_n(rd_inv_n[t]),
        .wr_out(wr_decoded[t*8+7:t*8])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Store, read and pin function outputs
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      store_valid <= 1'b0;
      store_data <= 64'h0000000000000000;
      store_keep <= 8'h00;
      rd_dq_valid <= 1'b0;
      rd_dq <= 64'h0000000000000000;
      rd_pin <= 8'hff;
      pin_func <= `WCC_PIN_NONE;
    end else begin
      store_valid <= wr_valid_s;
      store_data <= wr_decoded;
      store_keep <= dm_en ? wr_pin_s : 8'hff;
      rd_dq_valid <= rd_valid;
      rd_dq <= rd_encoded;
      rd_pin <= rd_inv_n;
      // Strobe outranks mask, which outranks inversion on the shared pin.
      if (strobe_en) begin
        pin_func <= `WCC_PIN_STRB;
      end else if (dm_en) begin
        pin_func <= `WCC_PIN_DM;
      end else if (wdbi_en | rdbi_en) begin
        pin_func <= `WCC_PIN_DBI;
      end else begin
        pin_func <= `WCC_PIN_NONE;
      end
    end
  end

endmodule

/* File: sim/wcc_alert_assertions.sv */
// Port assertions for the write checksum check and alert block.
// Assumes one pclk domain; bound to every instance of the block.
`include "wcc_map.vh"
module wcc_alert_chk #(
  parameter [7:0] CRC_PW = 8'h0a,
  parameter [7:0] PAR_PW = 8'h2e
) (
  input wire pclk,
  input wire presetn,
  input wire wr_valid,
  input wire par_err,
  input wire store_valid,
  input wire [7:0] store_keep,
  input wire rd_valid,
  input wire [63:0] rd_data,
  input wire rd_dq_valid,
  input wire [63:0] rd_dq,
  input wire [7:0] rd_pin,
  input wire [1:0] pin_func,
  input wire alert_out,
  input wire alert_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Pulse length helpers
  // ----
  // A parity cause is remembered until its pulse ends, as overlaps merge pulses.
  logic [7:0] run;
  logic par_flag;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run <= 8'h00;
      par_flag <= 1'b0;
    end else begin
      run <= alert_oe ? run + 8'h01 : 8'h00;
      par_flag <= par_err | (par_flag & ~$fell(alert_oe));
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----
  // Properties
  // ----
  property p_cause;
    $rose(alert_oe) |-> $past(wr_valid, 3) || $past(wr_valid, 4) || $past(wr_valid, 5)
      || $past(par_err, 1) || $past(par_err, 2);
  endproperty
  a_cause: assert property (p_cause) else $error("alert without a cause");
  property p_par_now;
    par_err |-> ##[1:2] alert_oe;
  endproperty
  a_par_now: assert property (p_par_now) else $error("parity alert missing");
  property p_crc_pw;
    $fell(alert_oe) |-> run >= CRC_PW;
  endproperty
  a_crc_pw: assert property (p_crc_pw) else $error("alert pulse too short");
  property p_par_pw;
    $fell(alert_oe) && par_flag |-> run >= PAR_PW;
  endproperty
  a_par_pw: assert property (p_par_pw) else $error("parity pulse too short");
  property p_drive_low;
    alert_oe |-> alert_out == 1'b0;
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("alert driven high");
  property p_store;
    wr_valid |-> ##[2:4] store_valid;
  endproperty
  a_store: assert property (p_store) else $error("burst not stored");
  property p_rd_path;
    rd_valid |=> rd_dq_valid && rd_dq[7:0] == ($past(rd_data[7:0]) ^ {8{~rd_pin[0]}});
  endproperty
  a_rd_path: assert property (p_rd_path) else $error("read lane mismatch");
  property p_rd_ones;
    rd_dq_valid && !rd_pin[0] |-> $countones(rd_dq[7:0]) > 4;
  endproperty
  a_rd_ones: assert property (p_rd_ones) else $error("inverted lane too low");
  property p_keep;
    store_valid && pin_func != `WCC_PIN_DM |-> store_keep == 8'hff;
  endproperty
  a_keep: assert property (p_keep) else $error("bytes masked without mask");
  c_crc: cover property ($fell(alert_oe) && run == CRC_PW);
  c_par: cover property ($fell(alert_oe) && par_flag);
  c_rd: cover property (rd_dq_valid && !rd_pin[0]);
endmodule
bind wcc_write_crc_alert wcc_alert_chk #(.CRC_PW(CRC_PW), .PAR_PW(PAR_PW)) wcc_alert_chk_inst (
  .pclk(pclk), .presetn(presetn), .wr_valid(wr_valid), .par_err(par_err),
  .store_valid(store_valid), .store_keep(store_keep), .rd_valid(rd_valid), .rd_data(rd_data),
  .rd_dq_valid(rd_dq_valid), .rd_dq(rd_dq), .rd_pin(rd_pin), .pin_func(pin_func),
  .alert_out(alert_out), .alert_oe(alert_oe));

/* File: sim/wcc_ctrl_model.sv */
// Controller model: sends chopped write bursts with checksums, pulls the
// alert line up and times each low period. Assumes one-cycle send pulses.
module wcc_ctrl_model (
  input logic pclk,
  input logic send,
  input logic nib,
  input logic chop,
  input logic bad,
  input logic use_pin,
  input logic [63:0] burst,
  input logic [7:0] pins,
  input logic alert_out,
  input logic alert_oe,
  output logic wr_valid,
  output logic wr_chop,
  output logic wr_addr_bit_two,
  output logic [63:0] wr_dq,
  output logic [7:0] wr_pin,
  output logic [7:0] wr_crc,
  output logic [7:0] low_len,
  output wire alert_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] run = 8'h00;
  int retries = 0;
  // Delay and burst index at each new low period, to size the replay window.
  logic [7:0] since = 8'h00;
  logic [7:0] worst_lat = 8'h00;
  logic [7:0] sent = 8'h00;
  logic [7:0] err_at = 8'h00;
  assign alert_n = alert_oe ? alert_out : 1'b1;
  function automatic logic [7:0] crc_of(input logic [63:0] b, input logic [7:0] p,
                                        input logic s, input logic u);
    logic [71:0] d;
    logic [7:0] c;
    d = {72{1'b1}};
    c = 8'h00;
    for (int q = 0; q < 8; q++)
      for (int t = 0; t < 4; t++)
        d[q*8+t] = b[(t+4*s)*8+q];
    for (int t = 0; t < 4; t++)
      d[64+t] = u ? p[t+4*s] : 1'b1;
    for (int i = 0; i < 72; i++)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  initial begin
    wr_valid = 1'b0;
    {wr_chop, wr_addr_bit_two, wr_dq, wr_pin, wr_crc, low_len} = '0;
  end
  always @(posedge pclk) begin
    wr_valid <= send;
    since <= send ? 8'h00 : since + {7'h00, since != 8'hff};
    if (send) begin
      sent <= sent + 8'h01;
      wr_chop <= chop;
      wr_addr_bit_two <= nib;
      wr_dq <= burst;
      wr_pin <= pins;
      wr_crc <= crc_of(burst, pins, nib, use_pin) ^ {7'h00, bad};
      low_len <= 8'h00;
    end else begin
      // Released lines do not keep their last value.
      {wr_chop, wr_addr_bit_two, wr_dq, wr_pin, wr_crc} <=
        ~{wr_chop, wr_addr_bit_two, wr_dq, wr_pin, wr_crc};
    end
    // A new low period is tied to the latest burst and its delay noted.
    if (alert_n == 1'b0 && run == 8'h00) begin
      err_at <= sent;
      if (since > worst_lat) worst_lat <= since;
    end
    // Any low length is accepted; short ones count as checksum retries.
    if (alert_n == 1'b0) begin
      run <= run + 8'h01;
    end else if (run != 8'h00) begin
      low_len <= run;
      run <= 8'h00;
      if (run < 8'd45) retries <= retries + 1;
    end
  end
endmodule

/* File: sim/testbench.sv */
// Self-checking bench for the write checksum check and alert block.
// Assumes the controller model in front of the burst pins.
`include "wcc_map.vh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] crc_pw = 8'h0a;
  localparam logic [7:0] par_pw = 8'h2e;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, par_err = 1'b0, rerr;
  logic [31:0] pwdata = 32'h0, rdata;
  logic rd_valid = 1'b0, rd_mpr = 1'b0;
  logic [63:0] rd_data = 64'h0, m_burst = 64'h0123456789abcdef;
  logic send = 1'b0, m_nib = 1'b0, m_chop = 1'b0, m_bad = 1'b0, m_use = 1'b0;
  logic [7:0] m_pins = 8'hff;
  wire [31:0] prdata;
  wire pready, pslverr, wr_valid, wr_chop, wr_addr_bit_two, store_valid, rd_dq_valid;
  wire [63:0] wr_dq, store_data, rd_dq;
  wire [7:0] wr_pin, wr_crc, store_keep, rd_pin, low_len;
  wire [1:0] pin_func;
  wire alert_out, alert_oe, alert_n;
  int fails = 0, total_checks = 0, cycles = 0;
  wcc_write_crc_alert #(.DEV_X4(0), .CRC_PW(crc_pw), .PAR_PW(par_pw)) wcc_write_crc_alert_inst (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wr_valid(wr_valid), .wr_chop(wr_chop), .wr_addr_bit_two(wr_addr_bit_two), .wr_dq(wr_dq),
    .wr_pin(wr_pin), .wr_crc(wr_crc), .par_err(par_err), .store_valid(store_valid),
    .store_data(store_data), .store_keep(store_keep), .rd_valid(rd_valid), .rd_mpr(rd_mpr),
    .rd_data(rd_data), .rd_dq_valid(rd_dq_valid), .rd_dq(rd_dq), .rd_pin(rd_pin),
    .pin_func(pin_func), .alert_out(alert_out), .alert_oe(alert_oe));
  wcc_ctrl_model wcc_ctrl_model_inst (
    .pclk(pclk), .send(send), .nib(m_nib), .chop(m_chop), .bad(m_bad), .use_pin(m_use),
    .burst(m_burst), .pins(m_pins), .alert_out(alert_out), .alert_oe(alert_oe),
    .wr_valid(wr_valid), .wr_chop(wr_chop), .wr_addr_bit_two(wr_addr_bit_two), .wr_dq(wr_dq),
    .wr_pin(wr_pin), .wr_crc(wr_crc), .low_len(low_len), .alert_n(alert_n));
  // ----
  // Bus and burst tasks
  // ----
  initial forever #5 pclk = ~pclk;
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    `CHK(n, e, rdata)
  endtask
  task automatic burst(input logic nib, chop, bad, u, input logic [7:0] p);
    @(posedge pclk);
    {send, m_nib, m_chop, m_bad, m_use, m_pins} <= {1'b1, nib, chop, bad, u, p};
    @(posedge pclk);
    send <= 1'b0;
  endtask
  // Waits for one whole low period, then compares its length.
  task automatic alert_len(input string n, input logic [7:0] e);
    int k;
    k = 0;
    while (alert_n !== 1'b0 && k < 40) begin
      @(posedge pclk);
      k++;
    end
    while (alert_n !== 1'b1 && k < 200) begin
      @(posedge pclk);
      k++;
    end
    repeat (2) @(posedge pclk);
    `CHK(n, e, low_len)
  endtask
  task automatic quiet(input string n);
    logic seen;
    seen = 1'b0;
    repeat (20) begin
      @(posedge pclk);
      if (alert_n !== 1'b1) seen = 1'b1;
    end
    `CHK(n, 1'b0, seen)
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_regs;
    logic [31:0] m5[4] = '{32'h0, 32'h400, 32'h800, 32'h0};
    logic [1:0] fn[4] = '{`WCC_PIN_NONE, `WCC_PIN_DM, `WCC_PIN_DBI, `WCC_PIN_STRB};
    rd_chk("mode five", 8'h00, 32'h0);
    rd_chk("flag reg", 8'h0c, 32'h0);
    apb(8'h14, 1'b1, 32'hffff);
    `CHK("unmapped", 1'b1, rerr)
    // Write inversion and masking are never set together.
    for (int i = 0; i < 4; i++) begin
      apb(8'h00, 1'b1, m5[i]);
      apb(8'h04, 1'b1, (i == 3) ? 32'h800 : 32'h0);
      repeat (2) @(posedge pclk);
      `CHK("pin func", fn[i], pin_func)
    end
    apb(8'h04, 1'b1, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_crc;
    logic [7:0] c;
    apb(8'h08, 1'b1, 32'h1000);
    burst(1'b0, 1'b1, 1'b0, 1'b0, 8'hff);
    quiet("good low");
    burst(1'b1, 1'b1, 1'b0, 1'b0, 8'hff);
    quiet("good high");
    apb(8'h00, 1'b1, 32'h400);
    burst(1'b0, 1'b1, 1'b0, 1'b1, 8'h5a);
    quiet("good pins");
    apb(8'h00, 1'b1, 32'h0);
    burst(1'b1, 1'b1, 1'b1, 1'b0, 8'hff);
    alert_len("crc pulse", crc_pw);
    `CHK("retry", 1, wcc_ctrl_model_inst.retries)
    `CHK("error burst", 8'h04, wcc_ctrl_model_inst.err_at)
    `CHK("replay depth", 1'b1, wcc_ctrl_model_inst.worst_lat < 8'h10)
    rd_chk("err bit", 8'h00, 32'h8);
    rd_chk("err flag", 8'h0c, 32'h80);
    c = wcc_ctrl_model_inst.crc_of(m_burst, 8'hff, 1'b1, 1'b0);
    rd_chk("status", 8'h10, {16'h0, c, 8'h05});
    apb(8'h00, 1'b1, 32'h8);
    rd_chk("err kept", 8'h00, 32'h8);
    apb(8'h00, 1'b1, 32'h0);
    rd_chk("err clear", 8'h0c, 32'h0);
    burst(1'b0, 1'b0, 1'b1, 1'b0, 8'hff);
    quiet("full burst");
    apb(8'h08, 1'b1, 32'h0);
    burst(1'b0, 1'b1, 1'b1, 1'b0, 8'hff);
    quiet("check off");
    rd_chk("err off", 8'h00, 32'h0);
    $display("test checksum done");
  endtask
  task automatic t_par;
    logic [7:0] c;
    @(posedge pclk);
    par_err <= 1'b1;
    @(posedge pclk);
    par_err <= 1'b0;
    alert_len("parity pulse", par_pw);
    rd_chk("no err bit", 8'h00, 32'h0);
    c = wcc_ctrl_model_inst.crc_of(m_burst, 8'hff, 1'b0, 1'b0);
    rd_chk("cause", 8'h10, {16'h0, c, 8'h00});
    `CHK("no retry", 1, wcc_ctrl_model_inst.retries)
    $display("test parity done");
  endtask
  task automatic t_dbi;
    int k;
    apb(8'h00, 1'b1, 32'h800);
    burst(1'b0, 1'b1, 1'b0, 1'b1, 8'hfe);
    k = 0;
    while (store_valid !== 1'b1 && k < 10) begin
      @(posedge pclk);
      k++;
    end
    `CHK("store data", m_burst ^ 64'hff, store_data)
    `CHK("store keep", 8'hff, store_keep)
    apb(8'h00, 1'b1, 32'h1000);
    for (int m = 0; m < 2; m++) begin
      @(posedge pclk);
      {rd_valid, rd_mpr, rd_data} <= {1'b1, m[0], 64'hffffffffff070f00};
      @(posedge pclk);
      rd_valid <= 1'b0;
      @(posedge pclk);
      `CHK("read data", m ? rd_data : 64'hfffffffffff80fff, rd_dq)
      `CHK("read pin", m ? 8'hff : 8'hfa, rd_pin)
    end
    $display("test inversion done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 6000) begin
      fails++;
      conclude;
    end
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_crc;
    t_par;
    t_dbi;
    conclude;
  end
endmodule
